// ===== sps_ctrl.sv
// Purpose: Controller end: spaces power-down entry and programs self-refresh temperature options.
// Assumes: User holds a request until granted; latencies given as static inputs.
//          Case temperature is sampled every clock with no filtering.
// Notes:   Spacing counters keep the longest pending delay, never the latest.
//          Termination lead before entry is left to the user of odt_in.
// Contract
//- Double refresh above 85C, quadruple above 95C.
//- No self refresh above 85C without option.
//- Extended bit selects self-refresh temperature range.
//- Automatic bit makes device manage refresh rate.
//- Extended bit forced zero when automatic on.
//- Enter power-down on low clock-enable with NOP.
//- Hold clock-enable high during reads, writes, MRS.
//- Power-down allowed during activate, precharge, refresh.
//- Wait one clock, or mode-set delay.
//- Slow exit makes termination asynchronous around it.
//- Device disables buffers in power-down.
//- Only NOP/DES until buffer disable delay.
//- Prefer entering power-down with DLL locked.
//- Reset DLL after exit if unlocked.
//- MR0 bit 12 picks fast or slow.
//- Exit on high clock-enable; wait exit latency.
`timescale 1ns/100ps
module sps_ctrl
   import sps_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        cmd_valid,
   input  wire sps_cmd_t    cmd_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [1:0]  mr_sel_in,
   output logic             cmd_ready,
   input  wire logic        pd_req,
   output logic             pd_active,
   input  wire logic        odt_in,
   input  wire logic [7:0]  read_latency,
   input  wire logic [7:0]  write_latency,
   input  wire logic [7:0]  write_recovery_time,
   input  wire logic        fixed_chop4_burst,
   input  wire logic        dll_locked,
   input  wire logic        automatic_refresh_rate,
   input  wire logic        extended_range_self_refresh,
   input  wire logic signed [7:0] case_temp_c,
   output logic [1:0]       refresh_rate_q,
   output logic             self_refresh_ok_q,
   output logic             dll_reset_needed_q,
   sps_if.ctrl              link
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] gap_q;
   logic [7:0] gap_d;
   logic [7:0] hold_q;
   logic       ref_after_exit_q;
   logic [7:0] since_exit_q;
   logic       pd_q;
   logic [7:0] tail;
   logic       go_cmd;
   logic       enter;
   logic       leave;
   logic [15:0] addr_fix;
   logic [7:0] need;

   // Chop-4 bursts end two clocks sooner, so their tail is shorter
   assign tail = fixed_chop4_burst ? BURST_TAIL_CHOP : BURST_TAIL_FULL;
   // Commands wait while powered down and during the exit latency
   // Refused requests simply stay pending; the user sees ready low, never a drop
   assign cmd_ready = !pd_q && (hold_q == 8'h00);
   assign go_cmd    = cmd_valid && cmd_ready;
   // Entry only once every spacing counter has run out
   // A command taken in this clock wins over entry, so clock enable never falls with it
   assign enter = pd_req && !pd_q && !go_cmd && (gap_q == 8'h00) && (hold_q == 8'h00)
                  && (!ref_after_exit_q || since_exit_q >= DLL_EXIT_DELAY);
   assign leave = !pd_req && pd_q && (hold_q == 8'h00);
   assign pd_active = pd_q;

   // Minimum delay from the last command to power-down entry
   // A short delay never cuts a longer one still pending, so a read then an activate keeps the read's wait
   always_comb begin
      need  = 8'h00;
      gap_d = (gap_q != 8'h00) ? gap_q - 8'h01 : 8'h00;
      if (go_cmd) begin
         case (cmd_in)
            SPS_CMD_ACT:  need = ACTIVATE_TO_SLEEP_DELAY;
            SPS_CMD_PRE:  need = PRECHARGE_TO_SLEEP_DELAY;
            SPS_CMD_REF:  need = REFRESH_TO_SLEEP_DELAY;
            SPS_CMD_MRS:  need = MODEREGSET_TO_SLEEP_DELAY;
            SPS_CMD_MPR,
            SPS_CMD_ZQ:   need = MODE_SET_DELAY;
            SPS_CMD_RD,
            SPS_CMD_RDAP: need = 8'(read_latency + 8'h05);
            SPS_CMD_WR:   need = 8'(write_latency + tail + write_recovery_time);
            SPS_CMD_WRAP: need = 8'(write_latency + tail + write_recovery_time + 8'h01);
            default:      need = 8'h00;
         endcase
         gap_d = (need > gap_q) ? need : gap_q;
      end
   end

   // Spacing counter; a value of n lets entry happen n cycles after the command
   // The count starts one lower because the command itself spends a clock on the pins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= 8'h00;
      end else begin
         gap_q <= (go_cmd && gap_d != 8'h00) ? gap_d - 8'h01 : gap_d;
      end
   end

   // Power-down state and the quiet time after entry or exit
   // Exit is only taken once the buffer disable quiet time has run out
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pd_q   <= 1'b0;
         hold_q <= 8'h00;
      end else if (enter) begin
         pd_q   <= 1'b1;
         hold_q <= BUFFER_DISABLE_DELAY;
      end else if (leave) begin
         pd_q   <= 1'b0;
         hold_q <= EXIT_LATENCY;
      end else if (hold_q != 8'h00) begin
         hold_q <= hold_q - 8'h01;
      end
   end

   // Track a refresh between exit and the next entry, timed from the exit
   // The age saturates, so a long awake spell never wraps back to a short one
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ref_after_exit_q <= 1'b0;
         since_exit_q     <= 8'h00;
      end else if (leave) begin
         ref_after_exit_q <= 1'b0;
         since_exit_q     <= 8'h00;
      end else begin
         if (go_cmd && cmd_in == SPS_CMD_REF) begin
            ref_after_exit_q <= 1'b1;
         end
         if (since_exit_q != 8'hFF) begin
            since_exit_q <= since_exit_q + 8'h01;
         end
      end
   end

   // An unlocked DLL at entry needs a DLL reset before reads rely on it
   // Only a DLL reset clears the flag; the user must not read until it drops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dll_reset_needed_q <= 1'b0;
      end else if (enter && !dll_locked) begin
         dll_reset_needed_q <= 1'b1;
      end else if (go_cmd && cmd_in == SPS_CMD_MRS && mr_sel_in == 2'h0 && addr_in[8]) begin
         dll_reset_needed_q <= 1'b0;
      end
   end

   // Refresh rate and self-refresh permission from case temperature
   // Above the extended ceiling self refresh is reported as not allowed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_rate_q    <= RATE_1X;
         self_refresh_ok_q <= 1'b1;
      end else begin
         if (case_temp_c > 8'(TEMP_2X_MAX_C)) begin
            refresh_rate_q <= RATE_4X;
         end else if (case_temp_c > 8'(TEMP_NORMAL_MAX_C)) begin
            refresh_rate_q <= RATE_2X;
         end else begin
            refresh_rate_q <= RATE_1X;
         end
         self_refresh_ok_q <= (case_temp_c <= 8'(TEMP_NORMAL_MAX_C))
                              || ((automatic_refresh_rate || extended_range_self_refresh)
                                  && case_temp_c <= 8'(TEMP_EXT_MAX_C));
      end
   end

   // Mode register two writes never carry both temperature bits
   always_comb begin
      addr_fix = addr_in;
      if (mr_sel_in == 2'h2) begin
         addr_fix[MR2_AUTO_BIT] = automatic_refresh_rate;
         addr_fix[MR2_EXT_BIT]  = extended_range_self_refresh && !automatic_refresh_rate;
      end
   end

   // Registered pins toward the device
   // Flopped so the device sees clean edges one clock after each decision
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         link.cmd        <= SPS_CMD_NOP;
         link.addr       <= 16'h0000;
         link.mr_sel     <= 2'h0;
         link.cke        <= 1'b0;
         link.odt        <= 1'b0;
         link.dram_rst_b <= 1'b0;
      end else begin
         link.cmd        <= go_cmd ? cmd_in : SPS_CMD_NOP;
         link.addr       <= go_cmd ? addr_fix : 16'h0000;
         link.mr_sel     <= go_cmd ? mr_sel_in : 2'h0;
         link.cke        <= !(enter || (pd_q && !leave));
         link.odt        <= odt_in;
         link.dram_rst_b <= 1'b1;
      end
   end
endmodule // sps_ctrl

// ===== sps_pkg.sv
// Purpose: Shared constants and types for the power-down and self-refresh temperature pair.
// Assumes: One clock, mclk at 200 MHz; command encodings are local to this pair.
// Notes:   Delays are in mclk cycles unless the name says otherwise.
package sps_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Commands carried from the controller end to the device end
   typedef enum logic [3:0] {
      SPS_CMD_NOP, SPS_CMD_DES, SPS_CMD_ACT, SPS_CMD_PRE, SPS_CMD_REF, SPS_CMD_MRS,
      SPS_CMD_RD, SPS_CMD_RDAP, SPS_CMD_WR, SPS_CMD_WRAP, SPS_CMD_MPR, SPS_CMD_ZQ
   } sps_cmd_t;
   // Power states of the device end
   typedef enum logic [1:0] {SPS_ST_ON, SPS_ST_PD_ACTIVE, SPS_ST_PD_FAST, SPS_ST_PD_SLOW} sps_state_t;
   // Mode register field positions
   localparam int unsigned MR0_PD_TYPE_BIT = 12;
   localparam int unsigned MR2_AUTO_BIT    = 6;
   localparam int unsigned MR2_EXT_BIT     = 7;
   localparam logic [15:0] MR0_RESET       = 16'h0000;
   localparam logic [15:0] MR2_RESET       = 16'h0000;
   // Delays in clocks
   localparam logic [7:0]  ACTIVATE_TO_SLEEP_DELAY  = 8'h01;
   localparam logic [7:0]  PRECHARGE_TO_SLEEP_DELAY = 8'h01;
   localparam logic [7:0]  REFRESH_TO_SLEEP_DELAY   = 8'h01;
   localparam logic [7:0]  MODE_SET_DELAY           = 8'h0C;
   localparam logic [7:0]  MODEREGSET_TO_SLEEP_DELAY = MODE_SET_DELAY;
   localparam logic [7:0]  BURST_TAIL_FULL          = 8'h04;
   localparam logic [7:0]  BURST_TAIL_CHOP          = 8'h02;
   localparam logic [7:0]  BUFFER_DISABLE_DELAY     = 8'h01;
   localparam logic [7:0]  TERMINATION_ASYNC_LEAD   = 8'h02;
   localparam logic [7:0]  EXIT_LATENCY             = 8'h03;
   // Exit to next entry after a refresh: greater of 10 clocks or 24 ns
   localparam int unsigned DLL_EXIT_MIN_CK = 10;
   localparam int unsigned DLL_EXIT_NS     = 24;
   localparam int unsigned DLL_EXIT_NS_CK  = (DLL_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0]  DLL_EXIT_DELAY  =
      8'((DLL_EXIT_NS_CK > DLL_EXIT_MIN_CK) ? DLL_EXIT_NS_CK : DLL_EXIT_MIN_CK);
   // Refresh periods in ms by case temperature band
   localparam int unsigned REF_PERIOD_NORMAL_MS = 64;
   localparam int unsigned REF_PERIOD_2X_MS     = 32;
   localparam int unsigned REF_PERIOD_4X_MS     = 16;
   localparam int          TEMP_NORMAL_MAX_C    = 85;
   localparam int          TEMP_2X_MAX_C        = 95;
   localparam int          TEMP_EXT_MAX_C       = 105;
   localparam logic [1:0]  RATE_1X = 2'h0;
   localparam logic [1:0]  RATE_2X = 2'h1;
   localparam logic [1:0]  RATE_4X = 2'h2;
   localparam logic [1:0]  RATE_AUTO = 2'h3;
   // Is this command a NOP or a deselect
   function automatic logic sps_is_idle_cmd(input sps_cmd_t c);
      return (c == SPS_CMD_NOP) || (c == SPS_CMD_DES);
   endfunction
endpackage

// ===== sps_if.sv
// Purpose: Command, clock-enable and reset link between controller and device ends.
// Assumes: Both ends run on mclk.
// Notes:   Termination control is a plain level from the controller.
`timescale 1ns/100ps
interface sps_if;
   import sps_pkg::*;
   sps_cmd_t    cmd;
   logic [15:0] addr;
   logic [1:0]  mr_sel;
   logic        cke;
   logic        odt;
   logic        dram_rst_b;
   modport ctrl (output cmd, output addr, output mr_sel, output cke, output odt, output dram_rst_b);
   modport dev  (input  cmd, input  addr, input  mr_sel, input  cke, input  odt, input  dram_rst_b);
endinterface

// ===== sps_dev.sv
// Purpose: Device end: power-down entry/exit, buffer gating, DLL and temperature modes.
// Assumes: Controller keeps its spacing; pins sampled on mclk.
// Notes:   Mode registers are loaded by MRS with mr_sel choosing the register.
`timescale 1ns/100ps
module sps_dev
   import sps_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        bank_open,
   output sps_state_t       pd_state_q,
   output logic             buffers_on_q,
   output logic             dll_on_q,
   output logic             odt_async_q,
   output logic             auto_rate_q,
   output logic             ext_range_q,
   output logic             illegal_mode_q,
   output logic [15:0]      mr0_q,
   output logic [15:0]      mr2_q,
   sps_if.dev               link
);
   ////////////////////////////////////////////////////////////////////////////
   logic       cke_prev_q;
   logic [7:0] async_cnt_q;
   logic       idle_cmd;
   logic       dev_rst;

   assign idle_cmd = sps_is_idle_cmd(link.cmd);
   assign dev_rst  = !link.dram_rst_b;

   // Mode registers; reset pin takes effect on the clock
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mr0_q <= MR0_RESET;
         mr2_q <= MR2_RESET;
      end else if (dev_rst) begin
         mr0_q <= MR0_RESET;
         mr2_q <= MR2_RESET;
      end else if (link.cke && link.cmd == SPS_CMD_MRS) begin
         if (link.mr_sel == 2'h0) begin
            mr0_q <= link.addr;
         end
         if (link.mr_sel == 2'h2) begin
            mr2_q <= link.addr;
         end
      end
   end

   // Temperature options decoded from mode register two
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         auto_rate_q    <= 1'b0;
         ext_range_q    <= 1'b0;
         illegal_mode_q <= 1'b0;
      end else begin
         auto_rate_q    <= mr2_q[MR2_AUTO_BIT];
         ext_range_q    <= mr2_q[MR2_EXT_BIT] && !mr2_q[MR2_AUTO_BIT];
         illegal_mode_q <= mr2_q[MR2_AUTO_BIT] && mr2_q[MR2_EXT_BIT];
      end
   end

   // Power state: entry and exit need a NOP or deselect with the edge of clock enable
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pd_state_q <= SPS_ST_ON;
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= link.cke;
         if (dev_rst) begin
            pd_state_q <= SPS_ST_ON;
         end else begin
            case (pd_state_q)
               SPS_ST_ON: begin
                  if (cke_prev_q && !link.cke && idle_cmd) begin
                     if (bank_open) begin
                        pd_state_q <= SPS_ST_PD_ACTIVE;
                     end else if (mr0_q[MR0_PD_TYPE_BIT]) begin
                        pd_state_q <= SPS_ST_PD_FAST;
                     end else begin
                        pd_state_q <= SPS_ST_PD_SLOW;
                     end
                  end
               end
               default: begin
                  if (link.cke && idle_cmd) begin
                     pd_state_q <= SPS_ST_ON;
                  end
               end
            endcase
         end
      end
   end

   // Buffers off in any power-down; DLL off only in slow-exit power-down
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         buffers_on_q <= 1'b1;
         dll_on_q     <= 1'b1;
      end else begin
         buffers_on_q <= (pd_state_q == SPS_ST_ON);
         dll_on_q     <= (pd_state_q != SPS_ST_PD_SLOW);
      end
   end

   // Termination runs asynchronous in slow exit and for the lead plus DLL delay after
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         odt_async_q <= 1'b0;
         async_cnt_q <= 8'h00;
      end else if (pd_state_q == SPS_ST_PD_SLOW) begin
         odt_async_q <= 1'b1;
         async_cnt_q <= 8'(TERMINATION_ASYNC_LEAD + DLL_EXIT_DELAY);
      end else if (async_cnt_q != 8'h00) begin
         odt_async_q <= 1'b1;
         async_cnt_q <= async_cnt_q - 8'h01;
      end else begin
         odt_async_q <= 1'b0;
      end
   end
endmodule // sps_dev

// ===== sps_props.sv
// Purpose: Assertions on the link that joins the controller end to the device end.
// Assumes: One clock domain; no fixed chop-4 bursts are used while these run.
// Notes:   Read and write spacing need the static latencies, handed in as parameters.
`timescale 1ns/100ps
module sps_props
   import sps_pkg::*;
#(
   parameter int RL  = 5,
   parameter int WL  = 5,
   parameter int WRT = 6
)(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire sps_cmd_t    cmd,
   input wire logic [15:0] addr,
   input wire logic [1:0]  mr_sel,
   input wire logic        cke,
   input wire logic        odt,
   input wire logic        dram_rst_b
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sps_cmd_t   last_q;
   logic [7:0] gap_q;
   logic [7:0] xgap_q;
   logic       cke_q;
   logic       ref_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Age of the last real command; saturates so long idle spans stay legal
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         last_q <= SPS_CMD_NOP;
         gap_q  <= 8'hFF;
      end else if (!(cmd inside {SPS_CMD_NOP, SPS_CMD_DES})) begin
         last_q <= cmd;
         gap_q  <= 8'h01;
      end else if (gap_q != 8'hFF) begin
         gap_q <= gap_q + 8'h01;
      end
   end
   // Clocks since the last exit, and whether a refresh came after it
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cke_q  <= 1'b0;
         xgap_q <= 8'hFF;
         ref_q  <= 1'b0;
      end else begin
         cke_q  <= cke;
         xgap_q <= (cke && !cke_q) ? 8'h01 : ((xgap_q == 8'hFF) ? xgap_q : xgap_q + 8'h01);
         ref_q  <= (cke && !cke_q) ? 1'b0 : ((cmd == SPS_CMD_REF) ? 1'b1 : (cke ? ref_q : 1'b0));
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_idle;
      cmd inside {SPS_CMD_NOP, SPS_CMD_DES};
   endsequence
   a_entry_with_idle: assert property ($fell(cke) |-> s_idle)
      else $error("clock enable fell with a real command");
   a_exit_with_idle: assert property ($rose(cke) |-> s_idle)
      else $error("clock enable rose with a real command");
   a_quiet_after_entry: assert property ($fell(cke) |=> s_idle)
      else $error("command inside buffer disable delay");
   a_quiet_after_exit: assert property ($rose(cke) |=> s_idle [*2])
      else $error("command inside exit latency");
   a_mode_set_gap: assert property ($fell(cke) && last_q inside {SPS_CMD_MRS, SPS_CMD_MPR, SPS_CMD_ZQ}
      |-> gap_q >= MODEREGSET_TO_SLEEP_DELAY)
      else $error("power-down too soon after mode set");
   a_read_gap: assert property ($fell(cke) && last_q inside {SPS_CMD_RD, SPS_CMD_RDAP} |-> gap_q >= RL + 5)
      else $error("power-down too soon after read");
   a_write_gap: assert property ($fell(cke) && last_q == SPS_CMD_WR |-> gap_q >= WL + 4 + WRT)
      else $error("power-down too soon after write");
   a_wrap_gap: assert property ($fell(cke) && last_q == SPS_CMD_WRAP |-> gap_q >= WL + 5 + WRT)
      else $error("power-down too soon after autoclose write");
   a_row_cmd_gap: assert property ($fell(cke) && last_q inside {SPS_CMD_ACT, SPS_CMD_PRE, SPS_CMD_REF}
      |-> gap_q >= 8'h01)
      else $error("power-down in the clock of a row command");
   a_refresh_exit_gap: assert property ($fell(cke) && ref_q |-> xgap_q >= 8'd10)
      else $error("re-entry too soon after exit with refresh");
   a_temp_bits_legal: assert property (cmd == SPS_CMD_MRS && mr_sel == 2'h2 |-> !(addr[6] && addr[7]))
      else $error("both self refresh temperature bits set");
endmodule // sps_props

// ===== sps_tb_top.sv
// Purpose: Self-checking bench joining the controller end to the device end.
// Assumes: Static latencies RL 5, WL 5, write recovery 6; no fixed chop-4.
// Notes:   Spacing is checked as a lower bound; the design may wait longer.
`timescale 1ns/100ps
module sps_tb_top;
   import sps_pkg::*;
   logic             mclk, rst_b, cmd_valid, cmd_ready, pd_req, pd_active, odt_in, dll_locked;
   logic             auto_rr, ext_rr, srok, dll_rn, bank_open, bufs, dll_on, odt_as, auto_q, ext_q, ill_q;
   sps_cmd_t         cmd_in;
   logic [15:0]      addr_in, mr0, mr2;
   logic [1:0]       mr_sel_in, rate;
   logic [7:0]       rl_v, wl_v, wr_v;
   logic signed [7:0] temp;
   sps_state_t       st;
   int               err_total, samples_checked;
   realtime          t_rise;
   sps_if link();
   sps_ctrl u_sps_ctrl (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_in(cmd_in), .addr_in(addr_in),
      .mr_sel_in(mr_sel_in), .cmd_ready(cmd_ready), .pd_req(pd_req), .pd_active(pd_active), .odt_in(odt_in),
      .read_latency(rl_v), .write_latency(wl_v), .write_recovery_time(wr_v), .fixed_chop4_burst(1'b0),
      .dll_locked(dll_locked), .automatic_refresh_rate(auto_rr), .extended_range_self_refresh(ext_rr),
      .case_temp_c(temp), .refresh_rate_q(rate), .self_refresh_ok_q(srok), .dll_reset_needed_q(dll_rn), .link(link));
   sps_dev u_sps_dev (.mclk(mclk), .rst_b(rst_b), .bank_open(bank_open), .pd_state_q(st), .buffers_on_q(bufs),
      .dll_on_q(dll_on), .odt_async_q(odt_as), .auto_rate_q(auto_q), .ext_range_q(ext_q),
      .illegal_mode_q(ill_q), .mr0_q(mr0), .mr2_q(mr2), .link(link));
   sps_props #(.RL(5), .WL(5), .WRT(6)) u_sps_props (.mclk(mclk), .rst_b(rst_b), .cmd(link.cmd),
      .addr(link.addr), .mr_sel(link.mr_sel), .cke(link.cke), .odt(link.odt), .dram_rst_b(link.dram_rst_b));
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Holds the request until the edge that takes it
   task automatic issue(input sps_cmd_t c, input logic [15:0] a, input logic [1:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_in    <= c;
      addr_in   <= a;
      mr_sel_in <= s;
      do begin
         @(posedge mclk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 300);
      chk(cmd_ready, 1'b1);
      cmd_valid <= 1'b0;
   endtask
   // Command, then power-down: spacing, entry, state, exit
   task automatic pd_after(input sps_cmd_t c, input int unsigned need, input sps_state_t es, input logic edll);
      int unsigned k;
      issue(c, 16'h0000, 2'h1);
      pd_req <= 1'b1;
      k = 0;
      while (link.cmd !== c && k < 50) begin
         @(posedge mclk);
         k++;
      end
      chk(link.cmd, c);
      k = 0;
      while (link.cke !== 1'b0 && k < 400) begin
         @(posedge mclk);
         k++;
      end
      chk(link.cke, 1'b0);
      chk(k >= need, 1'b1);
      chk(link.cmd inside {SPS_CMD_NOP, SPS_CMD_DES}, 1'b1);
      repeat (2) @(posedge mclk);
      chk(st, es);
      chk(dll_on, edll);
      chk(bufs, 1'b0);
      chk(odt_as, es == SPS_ST_PD_SLOW);
      pd_req <= 1'b0;
      k = 0;
      while (link.cke !== 1'b1 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      chk(link.cke, 1'b1);
      t_rise = $realtime;
      chk(cmd_ready, 1'b0);
      repeat (2) @(posedge mclk);
      chk(st, SPS_ST_ON);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_spacing();
      sps_cmd_t    ct[10] = '{SPS_CMD_ACT, SPS_CMD_PRE, SPS_CMD_REF, SPS_CMD_MRS, SPS_CMD_MPR, SPS_CMD_ZQ,
                              SPS_CMD_RD, SPS_CMD_RDAP, SPS_CMD_WR, SPS_CMD_WRAP};
      int unsigned nd[10] = '{1, 1, 1, 12, 12, 12, 10, 10, 15, 16};
      bank_open <= 1'b1;
      foreach (ct[i]) pd_after(ct[i], nd[i], SPS_ST_PD_ACTIVE, 1'b1);
      $display("spacing test done");
   endtask
   task automatic t_types_dll();
      dll_locked <= 1'b0;
      pd_after(SPS_CMD_ACT, 1, SPS_ST_PD_ACTIVE, 1'b1);
      chk(dll_rn, 1'b1);
      issue(SPS_CMD_MRS, 16'h1100, 2'h0);
      dll_locked <= 1'b1;
      bank_open  <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(dll_rn, 1'b0);
      pd_after(SPS_CMD_PRE, 1, SPS_ST_PD_FAST, 1'b1);
      issue(SPS_CMD_MRS, 16'h0000, 2'h0);
      pd_after(SPS_CMD_PRE, 1, SPS_ST_PD_SLOW, 1'b0);
      issue(SPS_CMD_REF, 16'h0000, 2'h1);
      pd_req <= 1'b1;
      while (link.cke !== 1'b0) @(posedge mclk);
      chk(($realtime - t_rise) >= 50.0, 1'b1);
      pd_req <= 1'b0;
      repeat (8) @(posedge mclk);
      $display("power-down type test done");
   endtask
   task automatic t_temp();
      logic signed [7:0] tv[6] = '{8'sd25, 8'sd85, 8'sd86, 8'sd95, 8'sd96, 8'sd105};
      logic [1:0]        rv[6] = '{RATE_1X, RATE_1X, RATE_2X, RATE_2X, RATE_4X, RATE_4X};
      foreach (tv[i]) begin
         temp <= tv[i];
         repeat (3) @(posedge mclk);
         chk(rate, rv[i]);
         chk(srok, tv[i] <= 85);
      end
      ext_rr <= 1'b1;
      issue(SPS_CMD_MRS, 16'h0080, 2'h2);
      repeat (3) @(posedge mclk);
      chk(srok, 1'b1);
      chk(ext_q, 1'b1);
      auto_rr <= 1'b1;
      issue(SPS_CMD_MRS, 16'h00C0, 2'h2);
      repeat (3) @(posedge mclk);
      chk(mr2[7], 1'b0);
      chk({auto_q, ill_q}, 2'h2);
      $display("temperature test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog at 10000 clocks: the whole sequence needs well under that
   initial begin
      #50000;
      err_total++;
      report_and_stop();
   end
   initial begin
      {rst_b, cmd_valid, pd_req, odt_in, auto_rr, ext_rr, bank_open} = 7'h00;
      {err_total, samples_checked} = '0;
      dll_locked = 1'b1;
      rl_v       = 8'h05;
      wl_v       = 8'h05;
      wr_v       = 8'h06;
      cmd_in     = SPS_CMD_NOP;
      addr_in    = 16'h0000;
      mr_sel_in  = 2'h0;
      temp       = 8'sd25;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      t_spacing();
      t_types_dll();
      t_temp();
      report_and_stop();
   end
endmodule // sps_tb_top
